// *** src/nfd_params.svh ***
// constants of the normalizing fraction divider: offsets, fields, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef NFD_PARAMS_SVH
`define NFD_PARAMS_SVH

// datapath widths
`define NFD_FRAC_W 60
`define NFD_SC_W 6
`define NFD_BUS_W 64
`define NFD_ADDR_W 3

// remainder bits that steer the sequencer
`define NFD_REM_SIGN 59
`define NFD_REM_B58 58
`define NFD_REM_B57 57

// register offsets on the plain port
`define NFD_OFS_REMAINDER 3'h0
`define NFD_OFS_DIVISOR 3'h1
`define NFD_OFS_QUOTIENT 3'h2
`define NFD_OFS_CONTROL 3'h3
`define NFD_OFS_STATUS 3'h4

// control word fields
`define NFD_CTL_START 0
`define NFD_CTL_NBITS_LO 8
`define NFD_CTL_NBITS_HI 13
`define NFD_CTL_DSIGN 16
`define NFD_CTL_SSIGN 17

// status word fields
`define NFD_ST_BUSY 0
`define NFD_ST_DONE 1
`define NFD_ST_QSIGN 2
`define NFD_ST_EXPINC 3
`define NFD_ST_NORM 4
`define NFD_ST_PAUSE_LO 8
`define NFD_ST_PAUSE_HI 10
`define NFD_ST_MPL 11
`define NFD_ST_MAA 12
`define NFD_ST_SC_LO 16
`define NFD_ST_SC_HI 21

// timing: clock period, basic shift rate, arithmetic pause
`define NFD_CLK_PERIOD_NS 4
`define NFD_BASIC_NS 50
`define NFD_PAUSE_NS 200
`define NFD_TICK_CYC (`NFD_BASIC_NS / `NFD_CLK_PERIOD_NS)
`define NFD_PAUSE_TICKS (`NFD_PAUSE_NS / `NFD_BASIC_NS)

// reset values
`define NFD_RST_SC 6'h00
`define NFD_RST_NBITS 6'h00

`endif

// *** src/nfd_pkg.sv ***
// types shared by the fraction divider and its pause ring
// assumes the constants header sits beside it in src/
`include "nfd_params.svh"

package nfd_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        NFD_IDLE = 2'b00,
        NFD_RUN = 2'b01,
        NFD_ADJUST = 2'b10
    } nfd_state_t;

    // arithmetic operation held across the pause
    typedef enum logic {
        NFD_OP_ADD = 1'b0,
        NFD_OP_SUB = 1'b1
    } nfd_op_t;

    // register port request from the controller
    typedef struct packed {
        logic [`NFD_ADDR_W-1:0] addr;
        logic [`NFD_BUS_W-1:0] wdata;
        logic wr;
        logic rd;
    } nfd_bus_req_t;

    // result indications toward the controller
    typedef struct packed {
        logic busy;
        logic done;
        logic quot_sign;
        logic exp_inc;
    } nfd_result_t;

    // three pause flip-flops
    typedef struct packed {
        logic pause_stage_a;
        logic pause_stage_b;
        logic pause_stage_c;
    } nfd_pause_t;

endpackage

// *** src/nfd_pause.sv ***
// pause ring: three flops that stretch an add or subtract over four ticks
// assumes go and tick come from logic on ref_clk, go only while idle
`timescale 1ns/1ps
`include "nfd_params.svh"

module nfd_pause (
    // clock and control
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // sequencing
    input wire logic tick,
    input wire logic go,
    // ring state
    output nfd_pkg::nfd_pause_t stages
);
    import nfd_pkg::*;

    nfd_pause_t s_ff;
    nfd_pause_t nxt_s;

    // ring: a sets, b follows, c follows, then all clear together
    always_comb begin
        nxt_s = s_ff;
        if (tick) begin
            if (s_ff.pause_stage_c) begin
                nxt_s = '0; // stage c lets the load through, ring resets [RULE_11]
            end else if (s_ff.pause_stage_b) begin
                nxt_s.pause_stage_c = 1'b1;
            end else if (s_ff.pause_stage_a) begin
                nxt_s.pause_stage_b = 1'b1;
            end else if (go) begin
                nxt_s.pause_stage_a = 1'b1; // four ticks per arithmetic step [RULE_14]
            end
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign stages = s_ff;

endmodule

// *** src/nfd_divider.sv ***
// fraction divider sequencer: non-restoring divide with normalizing shifts
// assumes a controller on ref_clk loads operands through the plain port
//
// What this block does
// [RULE_01] controller loads positive normalized operands, clears quotient
// [RULE_02] first step subtracts, shifts, inverted msb into quotient
// [RULE_03] normalized: subtract if positive, add if negative
// [RULE_04] normalized means sign bit differs from next
// [RULE_05] unnormalized: shift only, no arithmetic, until normalized
// [RULE_06] normalizing shift feeds uncomplemented msb into quotient
// [RULE_07] counter preset ones complement, ends at ones
// [RULE_08] next action from remainder bits 59, 58, 57
// [RULE_09] quotient sign is dividend sign xor divisor sign
// [RULE_10] quotient 1.x: shift right, increment exponent
// [RULE_11] each add or subtract stretched by pause ring
// [RULE_12] normalized flag tracks remainder, clear means shifting
// [RULE_13] pause ring enabled by normalized flag in divide
// [RULE_14] shifts at basic rate, pause four pulses
// [RULE_15] multiply pair and anticipate flops held cleared
// [RULE_16] one-cycle start request, done after counter and adjust
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "nfd_params.svh"

module nfd_divider (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input nfd_pkg::nfd_bus_req_t bus_req,
    output logic [`NFD_BUS_W-1:0] rd_data,
    // result toward the controller
    output nfd_pkg::nfd_result_t result
);
    import nfd_pkg::*;

    localparam int TICK_LAST_I = `NFD_TICK_CYC - 1;
    localparam logic [3:0] TICK_LAST = 4'(TICK_LAST_I);
    localparam logic [`NFD_SC_W-1:0] SC_END = '1;

    // all state of the sequencer
    typedef struct packed {
        nfd_state_t st;
        logic [`NFD_FRAC_W-1:0] remainder_reg;
        logic [`NFD_FRAC_W-1:0] divisor_reg;
        logic [`NFD_FRAC_W-1:0] quotient_reg;
        logic [`NFD_SC_W-1:0] shift_step_counter;
        logic [`NFD_SC_W-1:0] nbits;
        logic dest_sign_flop;
        logic src_sign_flop;
        logic quot_sign;
        logic exp_inc;
        logic done;
        logic remainder_normalized_flag;
        nfd_op_t op;
        logic multiplier_pair_low;
        logic multiply_arith_anticipate;
        logic [3:0] tick_cnt;
        logic [`NFD_BUS_W-1:0] rdata;
    } nfd_core_t;

    // next action decoded from the top three remainder bits
    typedef enum logic [1:0] {
        NFD_ACT_SHIFT = 2'b00,
        NFD_ACT_SUB = 2'b01,
        NFD_ACT_ADD = 2'b10
    } nfd_act_t;

    nfd_core_t s_ff;
    nfd_core_t nxt_s;
    nfd_pause_t pause;
    logic tick;
    logic pause_busy;
    logic pause_go;
    logic [`NFD_FRAC_W-1:0] alu_res;
    logic [2:0] top3;
    nfd_act_t act;
    logic [`NFD_BUS_W-1:0] status_word;
    logic [`NFD_SC_W-1:0] nbits_wr;

    // action table over bits 59, 58, 57
    function automatic nfd_act_t decide(input logic [2:0] t);
        nfd_act_t a;
        a = NFD_ACT_SHIFT;
        unique case (t)
            3'b010, 3'b011: a = NFD_ACT_SUB; // 0.1x positive
            3'b100, 3'b101: a = NFD_ACT_ADD; // 1.0x negative
            3'b000, 3'b001, 3'b110, 3'b111: a = NFD_ACT_SHIFT;
        endcase
        return a;
    endfunction

    // basic shift-rate strobe and pause ring
    assign tick = (s_ff.tick_cnt == TICK_LAST); // shifts paced every 12 clocks, 48 ns [RULE_14]
    assign pause_busy = pause.pause_stage_a | pause.pause_stage_b | pause.pause_stage_c;

    nfd_pause u_pause (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .tick(tick),
        .go(pause_go),
        .stages(pause)
    );

    // decision inputs and adder
    assign top3 = s_ff.remainder_reg[`NFD_REM_SIGN:`NFD_REM_B57]; // three msbs choose [RULE_08]
    assign act = decide(top3);
    assign alu_res = (s_ff.op == NFD_OP_SUB) ? (s_ff.remainder_reg - s_ff.divisor_reg)
                                             : (s_ff.remainder_reg + s_ff.divisor_reg);

    // pause starts only from a normalized remainder
    assign pause_go = (s_ff.st == NFD_RUN) && tick && !pause_busy
                      && (s_ff.shift_step_counter != SC_END)
                      && s_ff.remainder_normalized_flag; // normalized flag enables pause [RULE_13]

    assign nbits_wr = bus_req.wdata[`NFD_CTL_NBITS_HI:`NFD_CTL_NBITS_LO];

    // status word assembly
    always_comb begin
        status_word = '0;
        status_word[`NFD_ST_BUSY] = (s_ff.st != NFD_IDLE);
        status_word[`NFD_ST_DONE] = s_ff.done;
        status_word[`NFD_ST_QSIGN] = s_ff.quot_sign;
        status_word[`NFD_ST_EXPINC] = s_ff.exp_inc;
        status_word[`NFD_ST_NORM] = s_ff.remainder_normalized_flag;
        status_word[`NFD_ST_PAUSE_HI:`NFD_ST_PAUSE_LO] = pause;
        status_word[`NFD_ST_MPL] = s_ff.multiplier_pair_low;
        status_word[`NFD_ST_MAA] = s_ff.multiply_arith_anticipate;
        status_word[`NFD_ST_SC_HI:`NFD_ST_SC_LO] = s_ff.shift_step_counter;
    end

    // next-state logic of the whole sequencer
    always_comb begin
        nxt_s = s_ff;

        // free-running shift-rate divider
        if (tick) begin
            nxt_s.tick_cnt = 4'h0;
        end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + 4'h1;
        end

        // multiply-only flops stay cleared outside multiplication
        nxt_s.multiplier_pair_low = 1'b0; // [RULE_15]
        nxt_s.multiply_arith_anticipate = 1'b0; // [RULE_15]

        // read data stand only in the cycle after the strobe
        nxt_s.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `NFD_OFS_REMAINDER: nxt_s.rdata = `NFD_BUS_W'(s_ff.remainder_reg);
                `NFD_OFS_DIVISOR: nxt_s.rdata = `NFD_BUS_W'(s_ff.divisor_reg);
                `NFD_OFS_QUOTIENT: nxt_s.rdata = `NFD_BUS_W'(s_ff.quotient_reg);
                `NFD_OFS_CONTROL: begin
                    nxt_s.rdata[`NFD_CTL_NBITS_HI:`NFD_CTL_NBITS_LO] = s_ff.nbits;
                    nxt_s.rdata[`NFD_CTL_DSIGN] = s_ff.dest_sign_flop;
                    nxt_s.rdata[`NFD_CTL_SSIGN] = s_ff.src_sign_flop;
                end
                `NFD_OFS_STATUS: nxt_s.rdata = status_word;
                default: nxt_s.rdata = '0; // unmapped reads as zero
            endcase
        end

        // operand loading and start, accepted only while idle
        if (bus_req.wr && (s_ff.st == NFD_IDLE)) begin
            unique case (bus_req.addr)
                `NFD_OFS_REMAINDER: begin
                    nxt_s.remainder_reg = bus_req.wdata[`NFD_FRAC_W-1:0]; // dividend [RULE_01]
                end
                `NFD_OFS_DIVISOR: begin
                    nxt_s.divisor_reg = bus_req.wdata[`NFD_FRAC_W-1:0]; // divisor [RULE_01]
                end
                `NFD_OFS_QUOTIENT: begin
                    nxt_s.quotient_reg = bus_req.wdata[`NFD_FRAC_W-1:0]; // cleared by writing zero [RULE_01]
                end
                `NFD_OFS_CONTROL: begin
                    nxt_s.nbits = nbits_wr;
                    nxt_s.dest_sign_flop = bus_req.wdata[`NFD_CTL_DSIGN];
                    nxt_s.src_sign_flop = bus_req.wdata[`NFD_CTL_SSIGN];
                    if (bus_req.wdata[`NFD_CTL_START]) begin
                        nxt_s.st = NFD_RUN; // one-cycle start request [RULE_16]
                        nxt_s.shift_step_counter = ~nbits_wr; // ones complement preset [RULE_07]
                        nxt_s.done = 1'b0;
                        nxt_s.exp_inc = 1'b0;
                        nxt_s.quot_sign = bus_req.wdata[`NFD_CTL_DSIGN]
                                          ^ bus_req.wdata[`NFD_CTL_SSIGN]; // [RULE_09]
                    end
                end
                default: begin
                end
            endcase
        end

        unique case (s_ff.st)
            NFD_IDLE: begin
            end
            NFD_RUN: begin
                if (tick && pause.pause_stage_c) begin
                    // load the sum after the pause, then shift with inverted msb
                    nxt_s.remainder_reg = {alu_res[`NFD_FRAC_W-2:0], 1'b0}; // [RULE_11]
                    nxt_s.quotient_reg = {s_ff.quotient_reg[`NFD_FRAC_W-2:0],
                                          ~alu_res[`NFD_FRAC_W-1]}; // [RULE_02] [RULE_03]
                    nxt_s.shift_step_counter = s_ff.shift_step_counter + 6'h01; // [RULE_07]
                end else if (tick && !pause_busy) begin
                    if (s_ff.shift_step_counter == SC_END) begin
                        nxt_s.st = NFD_ADJUST; // all ones ends the divide [RULE_07]
                    end else if (pause_go) begin
                        // first pass sees a positive dividend, so it subtracts
                        if (act == NFD_ACT_ADD) begin
                            nxt_s.op = NFD_OP_ADD; // negative remainder adds [RULE_03]
                        end else begin
                            nxt_s.op = NFD_OP_SUB; // positive remainder subtracts [RULE_02] [RULE_03]
                        end
                    end else begin
                        // normalizing shift, no arithmetic, msb passes uncomplemented
                        nxt_s.remainder_reg = {s_ff.remainder_reg[`NFD_FRAC_W-2:0], 1'b0}; // [RULE_05] [RULE_12]
                        nxt_s.quotient_reg = {s_ff.quotient_reg[`NFD_FRAC_W-2:0],
                                              s_ff.remainder_reg[`NFD_REM_SIGN]}; // [RULE_06]
                        nxt_s.shift_step_counter = s_ff.shift_step_counter + 6'h01; // [RULE_07]
                    end
                end
            end
            NFD_ADJUST: begin
                // quotient of the form 1.x: right shift and bump exponent
                if ((s_ff.nbits != 6'h00) && s_ff.quotient_reg[s_ff.nbits - 6'h01]) begin
                    nxt_s.quotient_reg = {1'b0, s_ff.quotient_reg[`NFD_FRAC_W-1:1]}; // [RULE_10]
                    nxt_s.exp_inc = 1'b1; // [RULE_10]
                end
                nxt_s.st = NFD_IDLE;
                nxt_s.done = 1'b1; // done after counter and adjust [RULE_16]
            end
            default: begin
                nxt_s.st = NFD_IDLE; // unused code recovers to idle
            end
        endcase

        // normalized when sign and next bit differ
        nxt_s.remainder_normalized_flag = nxt_s.remainder_reg[`NFD_REM_SIGN]
                                          ^ nxt_s.remainder_reg[`NFD_REM_B58]; // [RULE_04] [RULE_12]
    end

    // state register, frozen while ce is low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_ff.st <= NFD_IDLE;
            s_ff.remainder_reg <= '0;
            s_ff.divisor_reg <= '0;
            s_ff.quotient_reg <= '0;
            s_ff.shift_step_counter <= `NFD_RST_SC;
            s_ff.nbits <= `NFD_RST_NBITS;
            s_ff.dest_sign_flop <= 1'b0;
            s_ff.src_sign_flop <= 1'b0;
            s_ff.quot_sign <= 1'b0;
            s_ff.exp_inc <= 1'b0;
            s_ff.done <= 1'b0;
            s_ff.remainder_normalized_flag <= 1'b0;
            s_ff.op <= NFD_OP_SUB;
            s_ff.multiplier_pair_low <= 1'b0;
            s_ff.multiply_arith_anticipate <= 1'b0;
            s_ff.tick_cnt <= 4'h0;
            s_ff.rdata <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // rd_data and result flags straight from flops, busy decoded from st
    assign rd_data = s_ff.rdata;
    assign result = '{busy: (s_ff.st != NFD_IDLE), done: s_ff.done, quot_sign: s_ff.quot_sign,
                      exp_inc: s_ff.exp_inc};

endmodule

// *** verification/nfd_divider_chk.sv ***
// checker: port timing of the fraction divider
// assumes one clock domain, bound into the nfd_divider module
`timescale 1ns/1ps
`include "nfd_params.svh"

module nfd_divider_chk (
    // clock and control
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ce,
    // register port and results
    input nfd_pkg::nfd_bus_req_t bus_req,
    input wire logic [`NFD_BUS_W-1:0] rd_data,
    input nfd_pkg::nfd_result_t result
);
    import nfd_pkg::*;
    logic go;
    logic sr;
    logic go_ff;
    logic sx_ff;
    // accepted start and status read
    assign go = ce && bus_req.wr && bus_req.addr == `NFD_OFS_CONTROL
        && bus_req.wdata[`NFD_CTL_START] && !result.busy;
    assign sr = ce && bus_req.rd && bus_req.addr == `NFD_OFS_STATUS;
    // start seen one cycle back, with its sign pair
    always_ff @(posedge ref_clk) begin
        go_ff <= go && !reset;
        sx_ff <= bus_req.wdata[`NFD_CTL_DSIGN] ^ bus_req.wdata[`NFD_CTL_SSIGN];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_start_sets_busy: assert property (go |=> result.busy && !result.done)
        else $error("busy or done wrong after start");
    chk_sign_at_start: assert property (go_ff |-> result.quot_sign == sx_ff)
        else $error("quotient sign not xor of signs");
    chk_sign_steady: assert property (result.busy |=> $stable(result.quot_sign))
        else $error("quotient sign moved while busy");
    chk_busy_min: assert property (go && bus_req.wdata[`NFD_CTL_NBITS_HI:`NFD_CTL_NBITS_LO] != 6'h0
        |=> result.busy [*8])
        else $error("busy too short");
    chk_done_drops_busy: assert property ($rose(result.done) |-> !result.busy)
        else $error("done while still busy");
    chk_done_holds: assert property (result.done && !go |=> result.done)
        else $error("done dropped without start");
    chk_mul_flops_clear: assert property (sr |=> !rd_data[`NFD_ST_MPL] && !rd_data[`NFD_ST_MAA])
        else $error("multiply flops not cleared");
    chk_pause_ring: assert property (sr |=> rd_data[`NFD_ST_PAUSE_HI:`NFD_ST_PAUSE_LO]
        inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("pause ring out of sequence");
    chk_pause_norm: assert property (sr |=> (rd_data[`NFD_ST_PAUSE_HI:`NFD_ST_PAUSE_LO] != 3'h4
        && rd_data[`NFD_ST_PAUSE_HI:`NFD_ST_PAUSE_LO] != 3'h6) || rd_data[`NFD_ST_NORM])
        else $error("pause without normalized flag");
    chk_rd_idle_zero: assert property (ce && !bus_req.rd |=> rd_data == '0)
        else $error("read data outside read cycle");
endmodule

bind nfd_divider nfd_divider_chk u_chk (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .bus_req(bus_req), .rd_data(rd_data), .result(result));

// *** verification/nfd_ctl_model.sv ***
// controller model: drives the register port of the divider
// assumes tasks are entered just after a rising edge of ref_clk
`timescale 1ns/1ps
`include "nfd_params.svh"

module nfd_ctl_model (
    // clock
    input wire logic ref_clk,
    // register port toward the divider
    output nfd_pkg::nfd_bus_req_t bus_req,
    input wire logic [`NFD_BUS_W-1:0] rd_data
);
    import nfd_pkg::*;
    // port idle from time zero
    initial bus_req = '0;
    // one write; strobe left up so writes run back to back
    task automatic put(input logic [2:0] a, input logic [63:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk);
    endtask
    // drop the strobes
    task automatic idle();
        bus_req <= '0;
        @(posedge ref_clk);
    endtask
    // one read; data taken in the following cycle only
    task automatic get(input logic [2:0] a, output logic [63:0] d);
        bus_req <= '{addr: a, wdata: 64'h0, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk);
        bus_req <= '0;
        @(posedge ref_clk);
        d = rd_data;
    endtask
    // operands in, quotient cleared, then a one-cycle start
    task automatic launch(input logic [59:0] dd, dv, input logic [5:0] n, input logic ds, ss);
        put(`NFD_OFS_REMAINDER, {4'h0, dd});
        put(`NFD_OFS_DIVISOR, {4'h0, dv});
        put(`NFD_OFS_QUOTIENT, 64'h0);
        put(`NFD_OFS_CONTROL, {46'h0, ss, ds, 2'h0, n, 8'h01});
        idle();
    endtask
endmodule

// *** verification/nfd_divider_test.sv ***
// testbench: whole divisions judged against a reference model
// assumes the checker binds itself and the controller model drives the port
`timescale 1ns/1ps
`include "nfd_params.svh"

module nfd_divider_test;
    import nfd_pkg::*;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic ce = 1'h1;
    nfd_bus_req_t bus_req;
    logic [`NFD_BUS_W-1:0] rd_data;
    nfd_result_t result;
    int fail_count = 0;
    int comparisons = 0;
    localparam logic [59:0] OP_A = 60'h600000000000000;
    localparam logic [59:0] OP_B = 60'h500000000000000;
    // design and controller
    nfd_divider DUT (.ref_clk(ref_clk), .reset(reset), .ce(ce), .bus_req(bus_req),
        .rd_data(rd_data), .result(result));
    nfd_ctl_model u_ctl (.ref_clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data));
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    // compare and count
    task automatic check(input string what, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // counts, verdict, end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // expected quotient, exponent flag and mix of steps
    function automatic void model(input logic [59:0] dd, dv, input int n,
        output logic [59:0] q, output logic ei, output int ar, output int sh);
        logic [59:0] r;
        r = dd;
        q = '0;
        ar = 0;
        sh = 0;
        for (int i = 0; i < n; i++) begin
            if (r[59] != r[58]) begin
                r = r[59] ? r + dv : r - dv;
                q = {q[58:0], ~r[59]};
                ar++;
            end else begin
                q = {q[58:0], r[59]};
                sh++;
            end
            r = r << 1;
        end
        ei = (n > 0) ? q[n-1] : 1'h0;
        if (ei) q = q >> 1;
    endfunction
    // one division end to end, with optional stall or meddling
    task automatic run(input logic [59:0] dd, dv, input int n, input logic ds, ss,
        input int stall, input bit meddle);
        logic [59:0] q;
        logic [63:0] st;
        logic ei;
        int ar, sh, t, cyc;
        model(dd, dv, n, q, ei, ar, sh);
        t = `NFD_TICK_CYC * (`NFD_PAUSE_TICKS * ar + sh);
        u_ctl.launch(dd, dv, n[5:0], ds, ss);
        if (meddle) begin
            u_ctl.put(`NFD_OFS_DIVISOR, 64'h7FF);
            u_ctl.put(`NFD_OFS_CONTROL, 64'h20101);
            u_ctl.put(`NFD_OFS_STATUS, 64'hFFFF);
            u_ctl.idle();
        end
        if (stall > 0) begin
            ce <= 1'h0;
            repeat (stall) @(posedge ref_clk);
            ce <= 1'h1;
        end
        cyc = 0;
        st = 64'h0;
        while (st[`NFD_ST_DONE] !== 1'h1 && cyc < 20000) begin
            u_ctl.get(`NFD_OFS_STATUS, st);
            cyc += 2;
        end
        if (cyc >= 20000) begin
            fail_count++;
            stop_test();
        end
        check("elapsed", cyc >= t - 20 && cyc <= t + 40, 1);
        check("done", result.done, 1);
        check("busy", result.busy, 0);
        check("sign", result.quot_sign, ds ^ ss);
        check("exp flag", result.exp_inc, ei);
        check("status", st & 64'h3F1F0F, {42'h0, 6'h3F, 12'h0, ei, ds ^ ss, 2'h2});
        u_ctl.get(`NFD_OFS_QUOTIENT, st);
        check("quotient", st, {4'h0, q});
    endtask
    // reset values, unmapped places read zero
    task automatic test_reset();
        logic [63:0] d;
        check("reset outputs", {60'h0, result}, 64'h0);
        for (int a = 0; a < 8; a++) begin
            u_ctl.get(a[2:0], d);
            check("reset read", d, 64'h0);
        end
        $display("test_reset done");
    endtask
    // dividend larger: quotient right shifted
    task automatic test_large();
        run(OP_A, OP_B, 6, 1'h0, 1'h0, 0, 0);
        $display("test_large done");
    endtask
    // divisor larger, every pair of signs
    task automatic test_signs();
        for (int k = 0; k < 4; k++) begin
            run(60'h400000000000000, OP_B, 6, k[1], k[0], 0, 0);
        end
        $display("test_signs done");
    endtask
    // sixty quotient bits with the clock enable stalled
    task automatic test_long();
        run(60'h5A3C96E1B2D4F07, 60'h4F1E2D3C4B5A697, 60, 1'h1, 1'h0, 30, 0);
        $display("test_long done");
    endtask
    // zero bits: counter already all ones
    task automatic test_zero();
        run(OP_A, OP_B, 0, 1'h0, 1'h1, 0, 0);
        $display("test_zero done");
    endtask
    // writes and a second start while busy change nothing
    task automatic test_refuse();
        run(OP_A, OP_B, 6, 1'h1, 1'h1, 0, 1);
        $display("test_refuse done");
    endtask
    // reset in mid-division abandons it
    task automatic test_abort();
        logic [63:0] d;
        u_ctl.launch(OP_A, OP_B, 6'h06, 1'h1, 1'h0);
        repeat (20) @(posedge ref_clk);
        reset <= 1'h1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'h0;
        check("abort outputs", {60'h0, result}, 64'h0);
        u_ctl.get(`NFD_OFS_STATUS, d);
        check("abort status", d, 64'h0);
        $display("test_abort done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'h0;
        test_reset();
        test_large();
        test_signs();
        test_long();
        test_zero();
        test_refuse();
        test_abort();
        stop_test();
    end
endmodule
